// [core/stc_timer_core.sv]
// sixteen-bit timer core with AHB-Lite register slave
`timescale 1ns/1ps
`include "stc_cfg.svh"
module stc_timer_core #(
  parameter bit LEGACY_MODE = 1'b0
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic EXT_COUNT_PIN,
  input wire logic CAPTURE_PIN,
  input wire logic COMPARATOR_OUT,
  output logic COMPARE_OUT_A,
  output logic COMPARE_OUT_B,
  output logic COMPARE_OUT_C,
  output logic IRQ,
  output logic AT_BOTTOM,
  output logic AT_MAX,
  output logic AT_TOP
);
  logic [7:0] timer_control_a, timer_control_b, temp_hi, mask;
  logic [15:0] count_value, capture_value, next_count, top;
  logic [15:0] cmp_buf [3];
  logic [15:0] cmp_act [3];
  logic [`STC_FLAG_W-1:0] flags, flag_set, flag_clr;
  logic [9:0] pre;
  logic [7:0] wr_addr, rd_addr, wd;
  logic [3:0] waveform_mode_field;
  logic [2:0] clock_select_field, match, force_hit, wave, ch_on;
  logic [1:0] com [3];
  logic [31:0] read_value;
  logic up, next_up, timer_tick, ovf, upd, wrap, cap_ev, pwm, a_top_pwm;
  logic ext_s1, ext_s2, ext_s3, wr_pend, rd_pend, acc;
  stc_pkg::stc_mode_t mode;

  // mode table: counting kind and TOP source per mode value
  function automatic stc_pkg::stc_mode_t mode_of(input logic [3:0] m);
    case (m)
      4'h1: mode_of = '{stc_pkg::K_PC, stc_pkg::TS_8};
      4'h2: mode_of = '{stc_pkg::K_PC, stc_pkg::TS_9};
      4'h3: mode_of = '{stc_pkg::K_PC, stc_pkg::TS_10};
      4'h4: mode_of = '{stc_pkg::K_CTC, stc_pkg::TS_A};
      4'h5: mode_of = '{stc_pkg::K_FAST, stc_pkg::TS_8};
      4'h6: mode_of = '{stc_pkg::K_FAST, stc_pkg::TS_9};
      4'h7: mode_of = '{stc_pkg::K_FAST, stc_pkg::TS_10};
      4'h8: mode_of = '{stc_pkg::K_PFC, stc_pkg::TS_ICR};
      4'h9: mode_of = '{stc_pkg::K_PFC, stc_pkg::TS_A};
      4'hA: mode_of = '{stc_pkg::K_PC, stc_pkg::TS_ICR};
      4'hB: mode_of = '{stc_pkg::K_PC, stc_pkg::TS_A};
      4'hC: mode_of = '{stc_pkg::K_CTC, stc_pkg::TS_ICR};
      4'hE: mode_of = '{stc_pkg::K_FAST, stc_pkg::TS_ICR};
      4'hF: mode_of = '{stc_pkg::K_FAST, stc_pkg::TS_A};
      default: mode_of = '{stc_pkg::K_NORMAL, stc_pkg::TS_MAX};
    endcase
  endfunction : mode_of

  // bus write strobe for one register offset
  function automatic logic wr_to(input logic [7:0] ofs);
    wr_to = wr_pend && (wr_addr == ofs);
  endfunction : wr_to

  assign waveform_mode_field = {timer_control_b[4:3], timer_control_a[1:0]};
  assign clock_select_field = timer_control_b[2:0];
  assign mode = mode_of(waveform_mode_field);
  assign pwm = (mode.kind != stc_pkg::K_NORMAL) && (mode.kind != stc_pkg::K_CTC);
  assign a_top_pwm = pwm && (mode.src == stc_pkg::TS_A);
  assign wd = HWDATA[7:0];
  assign acc = HSEL && HTRANS[1] && HREADY;
  assign ch_on = {~LEGACY_MODE, 2'b11};

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      com[i] = timer_control_a[`STC_COM_A_HI - 2 * i -: 2];
      force_hit[i] = wr_to(`STC_OFS_CTRL_C) && wd[`STC_FOC_A_BIT - i] && ch_on[i];
    end
  end

  // prescaler and external pin synchroniser
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pre <= 10'h000;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      pre <= pre + 10'h001;
      ext_s1 <= EXT_COUNT_PIN;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // clock select
  always_comb begin
    case (clock_select_field)
      3'h1: timer_tick = 1'b1;
      3'h2: timer_tick = (pre & `STC_PRE_DIV8) == `STC_PRE_DIV8;
      3'h3: timer_tick = (pre & `STC_PRE_DIV64) == `STC_PRE_DIV64;
      3'h4: timer_tick = (pre & `STC_PRE_DIV256) == `STC_PRE_DIV256;
      3'h5: timer_tick = pre == `STC_PRE_DIV1024;
      3'h6: timer_tick = ~ext_s2 & ext_s3;
      3'h7: timer_tick = ext_s2 & ~ext_s3;
      default: timer_tick = 1'b0;
    endcase
  end

  always_comb begin
    case (mode.src)
      stc_pkg::TS_8: top = `STC_TOP_8BIT;
      stc_pkg::TS_9: top = `STC_TOP_9BIT;
      stc_pkg::TS_10: top = `STC_TOP_10BIT;
      stc_pkg::TS_A: top = cmp_act[0];
      stc_pkg::TS_ICR: top = capture_value;
      default: top = `STC_MAX;
    endcase
  end

  // next counter value per counting kind
  always_comb begin
    next_count = count_value;
    next_up = up;
    ovf = 1'b0;
    upd = 1'b0;
    wrap = 1'b0;
    if (timer_tick) begin
      case (mode.kind)
        stc_pkg::K_CTC: begin
          ovf = count_value == `STC_MAX;
          if (count_value == top) next_count = `STC_BOTTOM;
          else next_count = count_value + 16'h0001;
        end
        stc_pkg::K_FAST: begin
          if (count_value >= top) begin
            next_count = `STC_BOTTOM;
            ovf = 1'b1;
            upd = 1'b1;
            wrap = 1'b1;
          end else begin
            next_count = count_value + 16'h0001;
          end
        end
        stc_pkg::K_PC, stc_pkg::K_PFC: begin
          if (up) begin
            if (count_value >= top) begin
              next_count = count_value - 16'h0001;
              next_up = 1'b0;
              upd = mode.kind == stc_pkg::K_PC;
            end else begin
              next_count = count_value + 16'h0001;
            end
          end else if (count_value == `STC_BOTTOM) begin
            next_count = count_value + 16'h0001;
            next_up = 1'b1;
            ovf = 1'b1;
            upd = mode.kind == stc_pkg::K_PFC;
          end else begin
            next_count = count_value - 16'h0001;
          end
        end
        default: begin
          ovf = count_value == `STC_MAX;
          next_count = count_value + 16'h0001;
        end
      endcase
    end
    if (wr_to(`STC_OFS_CNT_L)) next_count = {temp_hi, wd};
  end

  // counter and position reports
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      count_value <= `STC_BOTTOM;
      up <= 1'b1;
      AT_BOTTOM <= 1'b1;
      AT_MAX <= 1'b0;
      AT_TOP <= 1'b0;
    end else begin
      count_value <= next_count;
      up <= next_up;
      AT_BOTTOM <= next_count == `STC_BOTTOM;
      AT_MAX <= next_count == `STC_MAX;
      AT_TOP <= next_count == top;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      match[i] = timer_tick && ch_on[i] && (count_value == cmp_act[i]);
    end
  end

  // compare buffers: direct in non-PWM kinds, at update point otherwise
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      for (int i = 0; i < 3; i++) begin
        cmp_buf[i] <= 16'h0000;
        cmp_act[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_to(`STC_OFS_CMPA_L + 8'(8 * i))) cmp_buf[i] <= {temp_hi, wd};
        if (!pwm || upd) cmp_act[i] <= cmp_buf[i];
      end
    end
  end

  // waveform outputs
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      wave <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!ch_on[i]) begin
          wave[i] <= 1'b0;
        end else if (!pwm) begin
          if (match[i] || force_hit[i]) begin
            case (com[i])
              2'b01: wave[i] <= ~wave[i];
              2'b10: wave[i] <= 1'b0;
              2'b11: wave[i] <= 1'b1;
              default: wave[i] <= wave[i];
            endcase
          end
        end else if (!com[i][1] || (i == 0 && a_top_pwm)) begin
          wave[i] <= 1'b0;
        end else if (mode.kind == stc_pkg::K_FAST) begin
          if (match[i]) wave[i] <= com[i][0];
          else if (wrap) wave[i] <= ~com[i][0];
        end else if (match[i]) begin
          wave[i] <= up ? com[i][0] : ~com[i][0];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      COMPARE_OUT_A <= 1'b0;
      COMPARE_OUT_B <= 1'b0;
      COMPARE_OUT_C <= 1'b0;
    end else begin
      COMPARE_OUT_A <= wave[0];
      COMPARE_OUT_B <= wave[1];
      COMPARE_OUT_C <= wave[2];
    end
  end

  stc_capture_filter #(
    .FILTER_LEN(`STC_FILTER_LEN)
  ) u_capture (
    .clk(CORE_CLK),
    .reset(RESET),
    .pin_a(CAPTURE_PIN),
    .pin_b(COMPARATOR_OUT),
    .sel_b(timer_control_b[`STC_CAPSRC_BIT]),
    .filter_en(timer_control_b[`STC_NOISE_BIT]),
    .rising(timer_control_b[`STC_EDGE_BIT]),
    .event_pulse(cap_ev)
  );

  // single capture unit; frozen while it supplies TOP
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      capture_value <= 16'h0000;
    end else if (wr_to(`STC_OFS_CAP_L)) begin
      capture_value <= {temp_hi, wd};
    end else if (cap_ev && mode.src != stc_pkg::TS_ICR) begin
      capture_value <= count_value;
    end
  end

  assign flag_set = {cap_ev && mode.src != stc_pkg::TS_ICR, match, ovf};
  assign flag_clr = wr_to(`STC_OFS_FLAG) ? wd[`STC_FLAG_W-1:0] : '0;

  // flags: write one to clear, a new event wins
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      flags <= '0;
      IRQ <= 1'b0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
      IRQ <= |(flags & mask[`STC_FLAG_W-1:0]);
    end
  end

  // control bytes, mask and shared high-byte holding register
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      timer_control_a <= `STC_CTRL_RESET;
      timer_control_b <= `STC_CTRL_RESET;
      mask <= `STC_CTRL_RESET;
      temp_hi <= 8'h00;
    end else begin
      if (wr_to(`STC_OFS_CTRL_A)) timer_control_a <= wd;
      if (wr_to(`STC_OFS_CTRL_B)) timer_control_b <= wd;
      if (wr_to(`STC_OFS_MASK)) mask <= {3'h0, wd[`STC_FLAG_W-1:0]};
      if (wr_to(`STC_OFS_CNT_H) || wr_to(`STC_OFS_CMPA_H) || wr_to(`STC_OFS_CMPB_H)
          || wr_to(`STC_OFS_CMPC_H) || wr_to(`STC_OFS_CAP_H)) temp_hi <= wd;
      if (rd_pend && rd_addr == `STC_OFS_CNT_L) temp_hi <= count_value[15:8];
      if (rd_pend && rd_addr == `STC_OFS_CAP_L) temp_hi <= capture_value[15:8];
    end
  end

  always_comb begin
    case (rd_addr)
      `STC_OFS_CTRL_A: read_value = {24'h0, timer_control_a};
      `STC_OFS_CTRL_B: read_value = {24'h0, timer_control_b};
      `STC_OFS_CNT_L: read_value = {24'h0, count_value[7:0]};
      `STC_OFS_CNT_H: read_value = {24'h0, temp_hi};
      `STC_OFS_CMPA_L: read_value = {24'h0, cmp_buf[0][7:0]};
      `STC_OFS_CMPA_H: read_value = {24'h0, cmp_buf[0][15:8]};
      `STC_OFS_CMPB_L: read_value = {24'h0, cmp_buf[1][7:0]};
      `STC_OFS_CMPB_H: read_value = {24'h0, cmp_buf[1][15:8]};
      `STC_OFS_CMPC_L: read_value = {24'h0, cmp_buf[2][7:0]};
      `STC_OFS_CMPC_H: read_value = {24'h0, cmp_buf[2][15:8]};
      `STC_OFS_CAP_L: read_value = {24'h0, capture_value[7:0]};
      `STC_OFS_CAP_H: read_value = {24'h0, temp_hi};
      `STC_OFS_FLAG: read_value = {27'h0, flags};
      `STC_OFS_MASK: read_value = {24'h0, mask};
      default: read_value = 32'h0000_0000;
    endcase
  end

  // bus slave: writes land in data phase, reads add one wait state
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      wr_pend <= acc && HWRITE;
      rd_pend <= acc && !HWRITE;
      if (acc && HWRITE) wr_addr <= HADDR[7:0];
      if (acc && !HWRITE) begin
        rd_addr <= HADDR[7:0];
        HREADYOUT <= 1'b0;
      end
      if (rd_pend) begin
        HRDATA <= read_value;
        HREADYOUT <= 1'b1;
      end
    end
  end
endmodule : stc_timer_core

// [shared/stc_cfg.svh]
// register map, field positions, reset values and timing counts of the timer core
`ifndef STC_CFG_SVH
`define STC_CFG_SVH

`define STC_OFS_CTRL_A 8'h00
`define STC_OFS_CTRL_B 8'h04
`define STC_OFS_CTRL_C 8'h08
`define STC_OFS_CNT_L 8'h0C
`define STC_OFS_CNT_H 8'h10
`define STC_OFS_CMPA_L 8'h14
`define STC_OFS_CMPA_H 8'h18
`define STC_OFS_CMPB_L 8'h1C
`define STC_OFS_CMPB_H 8'h20
`define STC_OFS_CMPC_L 8'h24
`define STC_OFS_CMPC_H 8'h28
`define STC_OFS_CAP_L 8'h2C
`define STC_OFS_CAP_H 8'h30
`define STC_OFS_FLAG 8'h34
`define STC_OFS_MASK 8'h38

`define STC_CTRL_RESET 8'h00
`define STC_FLAG_OVF 0
`define STC_FLAG_CMPA 1
`define STC_FLAG_CAP 4
`define STC_FLAG_W 5
`define STC_FOC_A_BIT 7
`define STC_NOISE_BIT 7
`define STC_EDGE_BIT 6
`define STC_CAPSRC_BIT 5
`define STC_COM_A_HI 7

`define STC_BOTTOM 16'h0000
`define STC_MAX 16'hFFFF
`define STC_TOP_8BIT 16'h00FF
`define STC_TOP_9BIT 16'h01FF
`define STC_TOP_10BIT 16'h03FF

`define STC_PRE_DIV8 10'h007
`define STC_PRE_DIV64 10'h03F
`define STC_PRE_DIV256 10'h0FF
`define STC_PRE_DIV1024 10'h3FF
`define STC_FILTER_LEN 4

`endif

// [shared/stc_pkg.sv]
// types shared by the timer core
package stc_pkg;
  typedef enum logic [2:0] {
    K_NORMAL = 3'h0,
    K_CTC = 3'h1,
    K_FAST = 3'h3,
    K_PC = 3'h2,
    K_PFC = 3'h6
  } stc_kind_t;

  typedef enum logic [2:0] {
    TS_MAX = 3'h0,
    TS_8 = 3'h1,
    TS_9 = 3'h3,
    TS_10 = 3'h2,
    TS_A = 3'h6,
    TS_ICR = 3'h7
  } stc_top_src_t;

  typedef struct packed {
    stc_kind_t kind;
    stc_top_src_t src;
  } stc_mode_t;
endpackage : stc_pkg

// [core/stc_capture_filter.sv]
// capture input synchroniser, noise filter and edge detector
`timescale 1ns/1ps
`include "stc_cfg.svh"
module stc_capture_filter #(
  parameter int FILTER_LEN = `STC_FILTER_LEN
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic sel_b,
  input wire logic filter_en,
  input wire logic rising,
  output logic event_pulse
);
  logic a1, a2, b1, b2, stable, prev;
  logic [FILTER_LEN-1:0] hist;
  logic src;

  always_ff @(posedge clk) begin
    if (reset) begin
      a1 <= 1'b0;
      a2 <= 1'b0;
      b1 <= 1'b0;
      b2 <= 1'b0;
    end else begin
      a1 <= pin_a;
      a2 <= a1;
      b1 <= pin_b;
      b2 <= b1;
    end
  end

  assign src = sel_b ? b2 : a2;

  // with filter_en set, level only moves after a full run of equal samples; with it clear, it follows the synchronised pin
  always_ff @(posedge clk) begin
    if (reset) begin
      hist <= '0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else begin
      hist <= {hist[FILTER_LEN-2:0], src};
      prev <= stable;
      if (!filter_en) stable <= src;
      else if (&hist) stable <= 1'b1;
      else if (~|hist) stable <= 1'b0;
    end
  end

  assign event_pulse = rising ? (stable & ~prev) : (~stable & prev);
endmodule : stc_capture_filter

// [verif/stc_core_sva.sv]
// port-level assertions for the timer core
`timescale 1ns/1ps
`include "stc_cfg.svh"
module stc_core_sva (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic IRQ,
  input wire logic AT_BOTTOM,
  input wire logic AT_MAX,
  input wire logic AT_TOP
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic ph_wr;
  logic [7:0] ph_adr;
  logic [2:0] clk_sel;
  logic [3:0] mode;
  logic [4:0] mask;
  logic cnt_wr;
  assign cnt_wr = ph_wr && HREADY && ph_adr == `STC_OFS_CNT_L;
  // address phase capture
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ph_wr <= 1'b0;
      ph_adr <= 8'h00;
    end else if (HREADY) begin
      ph_wr <= HSEL && HTRANS[1] && HWRITE;
      ph_adr <= HADDR[7:0];
    end
  end
  // shadow of control fields
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      clk_sel <= 3'h0;
      mode <= 4'h0;
      mask <= 5'h00;
    end else if (ph_wr && HREADY) begin
      if (ph_adr == `STC_OFS_CTRL_B) begin
        clk_sel <= HWDATA[2:0];
        mode[3:2] <= HWDATA[4:3];
      end
      if (ph_adr == `STC_OFS_CTRL_A) begin
        mode[1:0] <= HWDATA[1:0];
      end
      if (ph_adr == `STC_OFS_MASK) begin
        mask <= HWDATA[4:0];
      end
    end
  end
  property p_okay;
    HRESP == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_rd_wait;
    HSEL && HTRANS[1] && HREADY && !HWRITE |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_fast;
    HSEL && HTRANS[1] && HREADY && HWRITE |=> HREADYOUT;
  endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  property p_ends;
    !(AT_BOTTOM && AT_MAX);
  endproperty
  a_ends: assert property (p_ends) else $error("bottom and max together");
  property p_top_max;
    mode == 4'h0 && $past(mode) == 4'h0 |-> AT_TOP == AT_MAX;
  endproperty
  a_top_max: assert property (p_top_max) else $error("top not max in mode 0");
  property p_stop;
    clk_sel == 3'h0 && $past(clk_sel) == 3'h0 && !cnt_wr
      |=> $stable(AT_BOTTOM) && $stable(AT_MAX);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved");
  property p_rst;
    $past(RESET) |-> AT_BOTTOM && !AT_MAX && !IRQ;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_mask;
    mask == 5'h00 && $past(mask) == 5'h00 && $past(mask, 2) == 5'h00 |-> !IRQ;
  endproperty
  a_mask: assert property (p_mask) else $error("irq with all masked");
endmodule : stc_core_sva

bind stc_timer_core stc_core_sva i_sva (.CORE_CLK(CORE_CLK), .RESET(RESET), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ), .AT_BOTTOM(AT_BOTTOM),
  .AT_MAX(AT_MAX), .AT_TOP(AT_TOP));

// [verif/stc_host_model.sv]
// bus master standing in for the processor core
`timescale 1ns/1ps
module stc_host_model (
  input wire logic clk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [7:0] dat,
      output logic [7:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, adr};
    htrans <= 2'h2;
    hwrite <= wr;
    hwdata <= ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, dat};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata[7:0];
  endtask : xfer
  // high byte first on write, low byte first on read
  task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
    logic [7:0] t;
    xfer(1'b1, lo + 8'h04, v[15:8], t);
    xfer(1'b1, lo, v[7:0], t);
  endtask : wr16
  task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
    xfer(1'b0, lo, 8'h00, v[7:0]);
    xfer(1'b0, lo + 8'h04, 8'h00, v[15:8]);
  endtask : rd16
endmodule : stc_host_model

// [verif/tb.sv]
// self-checking bench for the timer core
`timescale 1ns/1ps
`include "stc_cfg.svh"
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] pins = 3'h0;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic out_a;
  logic out_b;
  logic out_c;
  logic irq;
  logic at_bot;
  logic at_max;
  logic at_top;
  int miscompares = 0;
  int cmp_count = 0;
  logic [7:0] b;
  logic [15:0] v;
  logic [7:0] rst_adr [6] = '{8'h00, 8'h04, 8'h08, 8'h34, 8'h38, 8'h3C};
  always #20 clk = ~clk;
  stc_timer_core i_dut (.CORE_CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .EXT_COUNT_PIN(pins[2]),
    .CAPTURE_PIN(pins[0]), .COMPARATOR_OUT(pins[1]), .COMPARE_OUT_A(out_a),
    .COMPARE_OUT_B(out_b), .COMPARE_OUT_C(out_c), .IRQ(irq), .AT_BOTTOM(at_bot),
    .AT_MAX(at_max), .AT_TOP(at_top));
  stc_host_model i_host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_pin(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_pin
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] t;
    i_host.xfer(1'b1, a, d, t);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_host.xfer(1'b0, a, 8'h00, d);
  endtask : rd
  task automatic pulse(input int which, input int len);
    pins <= 3'h1 << which;
    repeat (len) @(posedge clk);
    pins <= 3'h0;
    repeat (8) @(posedge clk);
  endtask : pulse
  task automatic give_verdict();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (rst_adr[i]) begin
      rd(rst_adr[i], b);
      chk("reset value", 8'h00, b);
    end
    wr(8'h3C, 8'h5A);
    rd(8'h3C, b);
    chk("unmapped", 8'h00, b);
    wr(`STC_OFS_CTRL_C, 8'hE0);
    rd(`STC_OFS_CTRL_C, b);
    chk("force bits", 8'h00, b);
    wr(`STC_OFS_CTRL_A, 8'hA8);
    rd(`STC_OFS_CTRL_A, b);
    chk("ctrl a", 8'hA8, b);
    i_host.wr16(`STC_OFS_CNT_L, 16'h01FF);
    i_host.rd16(`STC_OFS_CNT_L, v);
    chk("count", 16'h01FF, v);
    repeat (20) @(posedge clk);
    i_host.rd16(`STC_OFS_CNT_L, v);
    chk("stopped count", 16'h01FF, v);
    for (int k = 0; k < 3; k++) begin
      i_host.wr16(`STC_OFS_CMPA_L + 8'(8 * k), 16'(16 * (k + 1)));
      i_host.rd16(`STC_OFS_CMPA_L + 8'(8 * k), v);
      chk("compare", 16'(16 * (k + 1)), v);
    end
    i_host.wr16(`STC_OFS_CNT_L, 16'h0000);
    wr(`STC_OFS_CTRL_B, 8'h01);
    repeat (80) @(posedge clk);
    wr(`STC_OFS_CTRL_B, 8'h00);
    rd(`STC_OFS_FLAG, b);
    chk("match flags", 8'h0E, b);
    wr(`STC_OFS_FLAG, 8'h1F);
    rd(`STC_OFS_FLAG, b);
    chk("flags cleared", 8'h00, b);
    wr(`STC_OFS_MASK, 8'h01);
    wr(`STC_OFS_CTRL_B, 8'h01);
    i_host.wr16(`STC_OFS_CNT_L, 16'hFFF0);
    for (int i = 0; i < 100 && at_max !== 1'b1; i++) @(posedge clk);
    chk_pin("max", 1'b1, at_max);
    for (int i = 0; i < 4 && at_bot !== 1'b1; i++) @(posedge clk);
    chk_pin("bottom", 1'b1, at_bot);
    repeat (3) @(posedge clk);
    chk_pin("irq", 1'b1, irq);
    wr(`STC_OFS_CTRL_B, 8'h00);
    wr(`STC_OFS_FLAG, 8'h1F);
    repeat (2) @(posedge clk);
    chk_pin("irq off", 1'b0, irq);
    wr(`STC_OFS_CTRL_A, 8'h74);
    for (int n = 0; n < 2; n++) begin
      wr(`STC_OFS_CTRL_C, 8'hE0);
      repeat (2) @(posedge clk);
      chk_pin("out a", n == 0, out_a);
      chk_pin("out b", 1'b1, out_b);
      chk_pin("out c", n == 0, out_c);
    end
    i_host.wr16(`STC_OFS_CNT_L, 16'h0000);
    wr(`STC_OFS_CTRL_B, 8'h09);
    for (int i = 0; i < 40 && at_top !== 1'b1; i++) @(posedge clk);
    chk_pin("ctc top", 1'b1, at_top);
    @(posedge clk);
    chk_pin("ctc wrap", 1'b1, at_bot);
    wr(`STC_OFS_CTRL_B, 8'h00);
    wr(`STC_OFS_FLAG, 8'h1F);
    for (int cs = 6; cs < 8; cs++) begin
      i_host.wr16(`STC_OFS_CNT_L, 16'h0000);
      wr(`STC_OFS_CTRL_B, 8'(cs));
      repeat (5) pulse(2, 4);
      wr(`STC_OFS_CTRL_B, 8'h00);
      i_host.rd16(`STC_OFS_CNT_L, v);
      chk("edge count", 16'h0005, v);
    end
    i_host.wr16(`STC_OFS_CNT_L, 16'h1234);
    for (int src = 0; src < 2; src++) begin
      wr(`STC_OFS_CTRL_B, 8'hC0 | 8'(src << 5));
      pulse(src, 2);
      rd(`STC_OFS_FLAG, b);
      chk("spike", 8'h00, b);
      pulse(src, 10);
      rd(`STC_OFS_FLAG, b);
      chk("capture flag", 8'h10, b);
      i_host.rd16(`STC_OFS_CAP_L, v);
      chk("capture", 16'h1234, v);
      wr(`STC_OFS_FLAG, 8'h10);
    end
    give_verdict();
  end
endmodule : tb
